// File: cce_front.sv
// APB register front end and launch sequencer of the elliptic-curve engine.
`timescale 1ns/1ps
//
// Overview of operation
// - Result pointer taken from configuration bits 20:16.
// - Operand B pointer from configuration bits 12:8.
// - Operand A pointer from configuration bits 4:0.
// - Bit 31 forces R mod N, self clears.
// - Command bit 30 is coefficient B sign.
// - Command bit 29 is coefficient A sign.
// - Command bits 15:8 give double-word operand length.
// - Build parameter bounds largest accepted operand length.
// - Length code two means 128-bit operands.
// - Prime field: three 192, four 256 bits.
// - Binary field: three 192, four 256 bits.
// - Command bits 6:0 give operation type, class.
// - Start launches; ignored while busy; self clears.
module cce_front #(
  parameter int max_operand_space_param = 3  // Log2 of double words reserved per operand.
) (
  input  wire logic        clk,                     // System clock, 250 MHz.
  input  wire logic        resetn,                  // Synchronous reset, active low.
  input  wire logic        psel,                    // APB select.
  input  wire logic        penable,                 // APB access phase.
  input  wire logic        pwrite,                  // APB write direction.
  input  wire logic [31:0] paddr,                   // APB byte address.
  input  wire logic [31:0] pwdata,                  // APB write data.
  output logic             pready,                  // APB ready.
  output logic [31:0]      prdata,                  // APB read data.
  output logic             pslverr,                 // APB error for unmapped address.
  output logic [4:0]       result_pointer,          // Result location in operand memory.
  output logic [4:0]       operand_a_pointer,       // Operand A location.
  output logic [4:0]       operand_b_pointer,       // Operand B location.
  output logic             coeff_a_sign,            // Sign of coefficient A.
  output logic             coeff_b_sign,            // Sign of coefficient B.
  output logic [7:0]       operand_length,          // Operand length in double words.
  output logic             field_binary,            // High for binary field.
  output logic [6:0]       operation_type,          // Operation type code.
  output logic [13:0]      operand_bits,            // Operand width of the running job.
  output logic [2:0]       run_class,               // Class of the running job.
  output logic             eng_recalc,              // Pulse: compute R mod N.
  output logic             eng_start,               // Pulse: run the operation.
  input  wire logic        eng_recalc_done,         // Pulse: R mod N is ready.
  input  wire logic        eng_done                 // Pulse: operation finished.
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  // All state of the block in one word.
  typedef struct packed {
    logic [4:0]          ptr_res;     // Result pointer.
    logic [4:0]          ptr_b;       // Operand B pointer.
    logic [4:0]          ptr_a;       // Operand A pointer.
    logic                recalc;      // R mod N request.
    logic                sign_b;      // Coefficient B sign.
    logic                sign_a;      // Coefficient A sign.
    logic [7:0]          len;         // Operand length code.
    logic                field;       // Field selector.
    logic [6:0]          optype;      // Operation type.
    logic                start;       // Start request.
    cce_pkg::cce_state_t st;          // Sequencer state.
    logic                err;         // Last start refused.
    logic [2:0]          cls;         // Latched class.
    logic [13:0]         bits;        // Latched operand width.
    logic                go_recalc;   // Recalculation pulse.
    logic                go_run;      // Operation pulse.
    logic [31:0]         rdata;       // Read data captured in setup.
    logic                slverr;      // Error captured in setup.
  } cce_regs_t;

  cce_regs_t s_q;  // Registered state.
  cce_regs_t s_d;  // Next state.

  logic        len_ok;    // Length within reserved space.
  logic        op_ok;     // Operation code defined.
  logic [2:0]  op_class;  // Decoded class.
  logic [13:0] op_bits;   // Decoded operand width.
  logic        wr;        // Write taking effect this edge.
  logic        setup;     // Setup cycle of any transfer.
  logic        busy;      // Sequencer not idle.

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True for every address that holds a register.
  function automatic logic addr_known(input logic [31:0] a);
    addr_known = (a == cce_pkg::ADDR_OPERAND_POINTERS) || (a == cce_pkg::ADDR_COMMAND) ||
                 (a == cce_pkg::ADDR_CONTROL) || (a == cce_pkg::ADDR_STATUS) ||
                 (a == cce_pkg::ADDR_VERSION);
  endfunction

  // Unmapped words fall to the default branch and read as zero.
  // Read value of a register; reserved bits stay zero.
  function automatic logic [31:0] read_word(input logic [31:0] a, input cce_regs_t s);
    logic [31:0] w;
    w = cce_pkg::RST_WORD;
    case (a)
      cce_pkg::ADDR_OPERAND_POINTERS: begin
        w[cce_pkg::PTR_RES_LSB +: cce_pkg::PTR_W] = s.ptr_res;
        w[cce_pkg::PTR_OPB_LSB +: cce_pkg::PTR_W] = s.ptr_b;
        w[cce_pkg::PTR_OPA_LSB +: cce_pkg::PTR_W] = s.ptr_a;
      end
      cce_pkg::ADDR_COMMAND: begin
        w[cce_pkg::CMD_RECALC] = s.recalc;
        w[cce_pkg::CMD_SIGN_B] = s.sign_b;
        w[cce_pkg::CMD_SIGN_A] = s.sign_a;
        w[cce_pkg::CMD_LEN_LSB +: cce_pkg::LEN_W] = s.len;
        w[cce_pkg::CMD_FIELD] = s.field;
        w[cce_pkg::CMD_OPT_LSB +: cce_pkg::OPT_W] = s.optype;
      end
      cce_pkg::ADDR_CONTROL: begin
        w[cce_pkg::CTL_START] = s.start;
      end
      cce_pkg::ADDR_STATUS: begin
        w[cce_pkg::STS_BUSY]   = (s.st != cce_pkg::ST_IDLE);
        w[cce_pkg::STS_RECALC] = (s.st == cce_pkg::ST_RECALC);
        w[cce_pkg::STS_ERROR]  = s.err;
      end
      cce_pkg::ADDR_VERSION: begin
        w = cce_pkg::VERSION_ID;
      end
      default: begin
        w = cce_pkg::RST_WORD;
      end
    endcase
    read_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decoder.

  // Classifies the programmed command for the launch check.
  // The decoder is purely combinational; its results matter only in idle and at launch.
  cce_op_decode #(
    .max_operand_space_param (max_operand_space_param)
  ) u_decode (
    .operand_length (s_q.len),
    .operation_type (s_q.optype),
    .len_ok         (len_ok),
    .op_ok          (op_ok),
    .op_class       (op_class),
    .operand_bits   (op_bits)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  // The slave never stalls, so every access phase completes in one cycle.
  // Setup and access are told apart by penable alone; psel qualifies both.
  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;
  assign setup  = psel && !penable;
  assign busy   = (s_q.st != cce_pkg::ST_IDLE);

  // Sequencer first, then bus writes, so a software set lands after a hardware clear.
  always_comb begin
    s_d           = s_q;
    s_d.go_recalc = 1'b0;
    s_d.go_run    = 1'b0;
    case (s_q.st)
      cce_pkg::ST_IDLE: begin
        if (s_q.start) begin
          if (!len_ok || !op_ok) begin
            // A bad length or code would index past the operand space.
            s_d.err   = 1'b1;
            s_d.start = 1'b0;
          end else if (s_q.recalc) begin
            s_d.err       = 1'b0;
            s_d.go_recalc = 1'b1;
            s_d.st        = cce_pkg::ST_RECALC;
          end else begin
            s_d.err    = 1'b0;
            s_d.go_run = 1'b1;
            s_d.cls    = op_class;
            s_d.bits   = op_bits;
            s_d.st     = cce_pkg::ST_RUN;
          end
        end
      end
      cce_pkg::ST_RECALC: begin
        if (eng_recalc_done) begin
          s_d.recalc = 1'b0;
          s_d.go_run = 1'b1;
          s_d.cls    = op_class;
          s_d.bits   = op_bits;
          s_d.st     = cce_pkg::ST_RUN;
        end
      end
      cce_pkg::ST_RUN: begin
        if (eng_done) begin
          s_d.start = 1'b0;
          s_d.st    = cce_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st = cce_pkg::ST_IDLE;
      end
    endcase
    // Settings are frozen while a job runs; the engine reads them live.
    if (wr && !busy) begin
      case (paddr)
        cce_pkg::ADDR_OPERAND_POINTERS: begin
          s_d.ptr_res = pwdata[cce_pkg::PTR_RES_LSB +: cce_pkg::PTR_W];
          s_d.ptr_b   = pwdata[cce_pkg::PTR_OPB_LSB +: cce_pkg::PTR_W];
          s_d.ptr_a   = pwdata[cce_pkg::PTR_OPA_LSB +: cce_pkg::PTR_W];
        end
        cce_pkg::ADDR_COMMAND: begin
          s_d.recalc = pwdata[cce_pkg::CMD_RECALC];
          s_d.sign_b = pwdata[cce_pkg::CMD_SIGN_B];
          s_d.sign_a = pwdata[cce_pkg::CMD_SIGN_A];
          s_d.len    = pwdata[cce_pkg::CMD_LEN_LSB +: cce_pkg::LEN_W];
          s_d.field  = pwdata[cce_pkg::CMD_FIELD];
          s_d.optype = pwdata[cce_pkg::CMD_OPT_LSB +: cce_pkg::OPT_W];
        end
        cce_pkg::ADDR_CONTROL: begin
          s_d.start = pwdata[cce_pkg::CTL_START];
        end
        default: begin
          s_d.start = s_d.start;  // Read-only and unmapped words ignore writes.
        end
      endcase
    end
    // Read data and error are prepared in setup so they leave flip-flops.
    if (setup) begin
      s_d.rdata  = pwrite ? cce_pkg::RST_WORD : read_word(paddr, s_q);
      s_d.slverr = !addr_known(paddr);
    end
  end

  // Registers the whole state word.
  // Synchronous reset clears every field, so the sequencer lands in idle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Every data output comes straight from the state word.
  // The error flag is gated by penable so that it only shows in the access phase.
  assign prdata            = s_q.rdata;
  assign pslverr           = penable && s_q.slverr;
  assign result_pointer    = s_q.ptr_res;
  assign operand_a_pointer = s_q.ptr_a;
  assign operand_b_pointer = s_q.ptr_b;
  assign coeff_a_sign      = s_q.sign_a;
  assign coeff_b_sign      = s_q.sign_b;
  assign operand_length    = s_q.len;
  assign field_binary      = s_q.field;
  assign operation_type    = s_q.optype;
  assign operand_bits      = s_q.bits;
  assign run_class         = s_q.cls;
  assign eng_recalc        = s_q.go_recalc;
  assign eng_start         = s_q.go_run;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Assertions watch the registered outputs one cycle after their cause.
  // They expect no command write to land in the very cycle of a launch.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A start that passes both the length and the code check while idle.
  logic idle_go;  // Valid start seen in idle.
  assign idle_go = (s_q.st == cce_pkg::ST_IDLE) && s_q.start && len_ok && op_ok;

  chk_ptr_store: assert property (
    wr && !busy && paddr == cce_pkg::ADDR_OPERAND_POINTERS |=> result_pointer ==
    $past(pwdata[20:16]) && operand_b_pointer == $past(pwdata[12:8]) &&
    operand_a_pointer == $past(pwdata[4:0]))
    else $error("Pointer fields not stored from write data.");

  chk_cmd_fields: assert property (
    wr && !busy && paddr == cce_pkg::ADDR_COMMAND |=> operand_length == $past(pwdata[15:8])
    && coeff_b_sign == $past(pwdata[30]) && coeff_a_sign == $past(pwdata[29])
    && field_binary == $past(pwdata[7]) && operation_type == $past(pwdata[6:0]))
    else $error("Command fields not stored from write data.");

  chk_recalc_first: assert property (
    idle_go && s_q.recalc |=> eng_recalc && !eng_start ##1 !eng_start[*2])
    else $error("Recalculation did not precede the operation.");

  chk_recalc_clear: assert property (
    s_q.st == cce_pkg::ST_RECALC && eng_recalc_done |=> !s_q.recalc && eng_start)
    else $error("Recalculation request not cleared or run not launched.");

  chk_direct_run: assert property (
    idle_go && !s_q.recalc |=> eng_start ##1 !eng_start && busy)
    else $error("Start did not launch exactly one run pulse.");

  chk_start_clear: assert property (
    s_q.st == cce_pkg::ST_RUN && eng_done |=> !s_q.start && !busy)
    else $error("Start bit not cleared at operation end.");

  chk_busy_ignore: assert property (
    busy && wr |=> $stable(operand_length) && $stable(result_pointer))
    else $error("Settings changed while an operation was running.");

  chk_len_bound: assert property (
    s_q.st == cce_pkg::ST_IDLE && s_q.start && !len_ok |=> !busy && s_q.err && !s_q.start)
    else $error("Out of range length was launched.");

  chk_width_map: assert property (
    eng_start |-> operand_bits == {operand_length, 6'h00})
    else $error("Operand width does not match the length code.");

  chk_resv_zero: assert property (
    setup && paddr == cce_pkg::ADDR_COMMAND |=> prdata[28:16] == 13'h0000)
    else $error("Reserved command bits read nonzero.");

  chk_op_refuse: assert property (
    s_q.st == cce_pkg::ST_IDLE && s_q.start && !op_ok |=> !busy && s_q.err && !s_q.start)
    else $error("Reserved operation code was launched.");

  chk_recalc_pulse: assert property (
    eng_recalc |=> !eng_recalc && busy)
    else $error("Recalculation pulse longer than one cycle.");

  chk_unmapped_read: assert property (
    setup && !addr_known(paddr) |=> prdata == 32'h0000_0000 && pslverr)
    else $error("Unmapped address did not read zero with an error.");

  chk_class_latch: assert property (
    eng_start |-> run_class == operation_type[6:4])
    else $error("Latched class does not match the operation type.");

  // Covers for the main flows.
  cov_plain_run: cover property (idle_go && !s_q.recalc ##1 eng_start);
  cov_recalc_run: cover property (eng_recalc ##[1:20] eng_start);
  cov_refused: cover property (s_q.start && !len_ok && !busy);
  cov_unmapped: cover property (psel && penable && pslverr);
  cov_binary_run: cover property (eng_start && field_binary);

endmodule // cce_front

// File: cce_pkg.sv
// Package with register map, field layout, reset values and state codes of the curve front end.
package cce_pkg;

  // Register byte addresses on the system bus.
  localparam logic [31:0] ADDR_OPERAND_POINTERS = 32'h5000_6000;
  localparam logic [31:0] ADDR_COMMAND          = 32'h5000_6004;
  localparam logic [31:0] ADDR_CONTROL          = 32'h5000_6008;
  localparam logic [31:0] ADDR_STATUS           = 32'h5000_600C;
  localparam logic [31:0] ADDR_VERSION          = 32'h5000_6010;

  // Pointer register layout.
  localparam int PTR_W        = 5;
  localparam int PTR_RES_LSB  = 16;
  localparam int PTR_OPB_LSB  = 8;
  localparam int PTR_OPA_LSB  = 0;

  // Command register layout.
  localparam int CMD_RECALC   = 31;
  localparam int CMD_SIGN_B   = 30;
  localparam int CMD_SIGN_A   = 29;
  localparam int LEN_W        = 8;
  localparam int CMD_LEN_LSB  = 8;
  localparam int CMD_FIELD    = 7;
  localparam int OPT_W        = 7;
  localparam int CMD_OPT_LSB  = 0;
  localparam int CLASS_W      = 3;
  localparam int BITS_W       = 14;
  localparam int DWORD_SHIFT  = 6;

  // Control and status layout.
  localparam int CTL_START    = 0;
  localparam int STS_BUSY     = 0;
  localparam int STS_RECALC   = 1;
  localparam int STS_ERROR    = 2;

  // Reset values.
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [31:0] VERSION_ID = 32'h0001_0000;  // Value is arbitrary.

  // Operation classes held in the top three bits of the operation type.
  localparam logic [2:0] CLS_ARITH  = 3'h0;
  localparam logic [2:0] CLS_MODMUL = 3'h1;
  localparam logic [2:0] CLS_CURVE  = 3'h2;
  localparam logic [2:0] CLS_SIGN   = 3'h3;

  // Highest valid sub-code per class, and the reserved arithmetic sub-code.
  localparam logic [3:0] ARITH_MAX  = 4'hA;
  localparam logic [3:0] ARITH_RES  = 4'h7;
  localparam logic [3:0] HIGH_MAX   = 4'h2;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RECALC = 2'b01,
    ST_RUN    = 2'b10
  } cce_state_t;

endpackage

// File: cce_op_decode.sv
// Decoder that classifies the programmed operation and checks the operand length.
`timescale 1ns/1ps
module cce_op_decode #(
  parameter int max_operand_space_param = 3  // Log2 of double words reserved per operand.
) (
  input  wire logic [7:0]  operand_length,  // Length code in 64-bit double words.
  input  wire logic [6:0]  operation_type,  // Operation type field.
  output logic             len_ok,          // Length code is within the reserved space.
  output logic             op_ok,           // Operation code is a defined one.
  output logic [2:0]       op_class,        // Operation class.
  output logic [13:0]      operand_bits     // Operand width in bits.
);

  // Widest length the build can hold; a one-bit wider count avoids overflow.
  localparam logic [8:0] MAX_LEN = 9'(1 << max_operand_space_param);

  logic [3:0] sub;  // Code within the class.

  // Class and sub-code split, length check and bit width.
  always_comb begin
    op_class     = operation_type[6:4];
    sub          = operation_type[3:0];
    len_ok       = (operand_length != 8'h00) && ({1'b0, operand_length} <= MAX_LEN);
    operand_bits = {operand_length, 6'h00};
    case (op_class)
      cce_pkg::CLS_ARITH: begin
        op_ok = (sub != 4'h0) && (sub != cce_pkg::ARITH_RES) && (sub <= cce_pkg::ARITH_MAX);
      end
      cce_pkg::CLS_MODMUL,
      cce_pkg::CLS_SIGN: begin
        op_ok = (sub <= cce_pkg::HIGH_MAX);
      end
      cce_pkg::CLS_CURVE: begin
        op_ok = 1'b1;
      end
      default: begin
        op_ok = 1'b0;  // Upper four classes are reserved.
      end
    endcase
  end

endmodule // cce_op_decode

// File: tb_curve_engine_config_command.sv
// Self-checking testbench for the curve engine register front end and launch sequencer.
`timescale 1ns/1ps
module tb_curve_engine_config_command;
  ////////////////////////////////////////////////////////////////////////////////
  logic        clk;              // System clock.
  logic        resetn;           // Synchronous reset, active low.
  logic        psel;             // APB select.
  logic        penable;          // APB access phase.
  logic        pwrite;           // APB direction.
  logic [31:0] paddr;            // APB address.
  logic [31:0] pwdata;           // APB write data.
  logic        pready;           // APB ready.
  logic [31:0] prdata;           // APB read data.
  logic        pslverr;          // APB error.
  logic [4:0]  result_pointer;   // Result location.
  logic [4:0]  operand_a_pointer; // Operand A location.
  logic [4:0]  operand_b_pointer; // Operand B location.
  logic        coeff_a_sign;     // Sign of A.
  logic        coeff_b_sign;     // Sign of B.
  logic [7:0]  operand_length;   // Length in double words.
  logic        field_binary;     // Binary field select.
  logic [6:0]  operation_type;   // Operation code.
  logic [13:0] operand_bits;     // Width of running job.
  logic [2:0]  run_class;        // Class of running job.
  logic        eng_recalc;       // Recalc pulse.
  logic        eng_start;        // Start pulse.
  logic        eng_recalc_done;  // Recalc finished pulse.
  logic        eng_done;         // Operation finished pulse.
  int          n_fail;           // Mismatches seen.
  int          num_checks;       // Comparisons made.
  int          n_start;          // Start pulses seen.
  int          cyc;              // Cycle counter for the hang guard.
  integer      seed;             // Random seed.
  logic [33:0] notes[$];         // Expected transfer results: read flag, error, data.
  logic [31:0] ptr_exp;          // Pointer register as software last set it.
  logic [6:0]  ops[6];           // Valid operation codes spread over the classes.

  cce_front #(.max_operand_space_param(3)) cce_front_inst (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .result_pointer(result_pointer), .operand_a_pointer(operand_a_pointer),
    .operand_b_pointer(operand_b_pointer), .coeff_a_sign(coeff_a_sign),
    .coeff_b_sign(coeff_b_sign), .operand_length(operand_length),
    .field_binary(field_binary), .operation_type(operation_type),
    .operand_bits(operand_bits), .run_class(run_class), .eng_recalc(eng_recalc),
    .eng_start(eng_start), .eng_recalc_done(eng_recalc_done), .eng_done(eng_done));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the expected answer is queued for the monitor.
  task automatic apb(input logic wr, input logic [31:0] a, d, exp, input logic err);
    notes.push_back({~wr, err, exp});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // The request is held until ready is sampled high.
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Monitor: every completed access phase is matched against the oldest note.
  always @(posedge clk) begin
    logic [33:0] note;
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      check({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) begin
        check(prdata, note[31:0]);
      end
    end
  end

  // Counts start pulses and guards against a hang.
  always @(posedge clk) begin
    if (eng_start === 1'b1) begin
      n_start <= n_start + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Programs a command and starts it; a refused command must give no pulse.
  task automatic launch(input logic [31:0] cmd, input logic good);
    int n;
    int s0;
    s0 = n_start;
    apb(1'b1, cce_pkg::ADDR_COMMAND, cmd, 32'h0, 1'b0);
    check({24'h0, operand_length}, {24'h0, cmd[15:8]});
    check({31'h0, field_binary}, {31'h0, cmd[7]});
    check({25'h0, operation_type}, {25'h0, cmd[6:0]});
    check({30'h0, coeff_b_sign, coeff_a_sign}, {30'h0, cmd[30:29]});
    apb(1'b1, cce_pkg::ADDR_CONTROL, 32'h1, 32'h0, 1'b0);
    if (good && cmd[31]) begin
      for (n = 0; n < 20 && eng_recalc !== 1'b1; n++) @(posedge clk);
      check({31'h0, eng_recalc}, 32'h1);
      // Busy and recalculating, no start until the engine reports back.
      apb(1'b0, cce_pkg::ADDR_STATUS, 32'h0, 32'h3, 1'b0);
      check(n_start, s0);
      eng_recalc_done <= 1'b1;
      @(posedge clk);
      eng_recalc_done <= 1'b0;
    end
    for (n = 0; n < 20 && eng_start !== 1'b1; n++) @(posedge clk);
    if (!good) begin
      check(n_start, s0);
      apb(1'b0, cce_pkg::ADDR_STATUS, 32'h0, 32'h4, 1'b0);
      return;
    end
    check({31'h0, eng_start}, 32'h1);
    check({18'h0, operand_bits}, {18'h0, cmd[15:8], 6'h0});
    check({29'h0, run_class}, {29'h0, cmd[6:4]});
    // While busy: recalc bit already cleared, settings frozen, restart ignored.
    apb(1'b0, cce_pkg::ADDR_COMMAND, 32'h0, cmd & 32'h6000_FFFF, 1'b0);
    apb(1'b0, cce_pkg::ADDR_STATUS, 32'h0, 32'h1, 1'b0);
    apb(1'b1, cce_pkg::ADDR_OPERAND_POINTERS, 32'h001F_1F1F, 32'h0, 1'b0);
    apb(1'b1, cce_pkg::ADDR_CONTROL, 32'h1, 32'h0, 1'b0);
    apb(1'b0, cce_pkg::ADDR_OPERAND_POINTERS, 32'h0, ptr_exp, 1'b0);
    apb(1'b0, cce_pkg::ADDR_CONTROL, 32'h0, 32'h1, 1'b0);
    check(n_start, s0 + 1);
    eng_done <= 1'b1;
    @(posedge clk);
    eng_done <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, cce_pkg::ADDR_CONTROL, 32'h0, 32'h0, 1'b0);
    apb(1'b0, cce_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [31:0] w;
    resetn = 1'b0;
    {psel, penable, pwrite, eng_recalc_done, eng_done} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    {n_fail, num_checks, n_start, cyc} = '0;
    seed = 32'h2f81;
    ptr_exp = 32'h0;
    ops = '{7'h01, 7'h2A, 7'h12, 7'h30, 7'h08, 7'h22};
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Reset values, read-only places and an unmapped address.
    apb(1'b0, cce_pkg::ADDR_OPERAND_POINTERS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, cce_pkg::ADDR_COMMAND, 32'h0, 32'h0, 1'b0);
    apb(1'b1, cce_pkg::ADDR_VERSION, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, cce_pkg::ADDR_VERSION, 32'h0, cce_pkg::VERSION_ID, 1'b0);
    apb(1'b1, 32'h5000_6014, 32'h1, 32'h0, 1'b1);
    apb(1'b0, 32'h5000_6014, 32'h0, 32'h0, 1'b1);
    // Random pointers; reserved bits must drop.
    repeat (4) begin
      w = $random(seed);
      ptr_exp = w & 32'h001F_1F1F;
      apb(1'b1, cce_pkg::ADDR_OPERAND_POINTERS, w, 32'h0, 1'b0);
      apb(1'b0, cce_pkg::ADDR_OPERAND_POINTERS, 32'h0, ptr_exp, 1'b0);
      check({27'h0, result_pointer}, {27'h0, w[20:16]});
      check({27'h0, operand_b_pointer}, {27'h0, w[12:8]});
      check({27'h0, operand_a_pointer}, {27'h0, w[4:0]});
    end
    // Random command words read back with reserved bits cleared.
    repeat (3) begin
      w = $random(seed) & 32'h7FFF_FFFF;
      apb(1'b1, cce_pkg::ADDR_COMMAND, w, 32'h0, 1'b0);
      apb(1'b0, cce_pkg::ADDR_COMMAND, 32'h0, w & 32'hE000_FFFF, 1'b0);
    end
    // Refused launches: lengths out of range and reserved operation codes.
    launch(32'h0000_0001, 1'b0);
    launch(32'h0000_0901, 1'b0);
    launch(32'h0000_0200, 1'b0);
    launch(32'h0000_0247, 1'b0);
    launch(32'h0000_0213, 1'b0);
    // Good launches over lengths two to four and eight, both fields, with and without recalc.
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      launch({i == 2 || i == 5, w[30:29], 13'h0, 8'(2 + i % 3), i >= 3, ops[i]}, 1'b1);
    end
    launch(32'h8000_0808, 1'b1);
    wrap_up();
  end
endmodule // tb_curve_engine_config_command
